/* gxrp_chk.sv */
// Checker for the expander read path: reset state and the pin output stage.
// Assumes it is bound to gxrp_core and sees only that module's ports.
`timescale 1ns/10ps
module gxrp_chk (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  input wire logic [2:0] addr_sel,
  input wire logic [15:0] pin_i,
  input wire logic [15:0] out_val,
  input wire logic [15:0] dir_in,
  input wire logic [31:0] drv_code,
  input wire logic [15:0] pin_o,
  input wire logic [15:0] pin_oe_n,
  input wire logic [63:0] pull_up_fing,
  input wire logic [63:0] pull_dn_fing,
  input wire logic int_n
);
  // ************************************************************
  // Properties, all on the rising edge of ref_clk
  // ************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  // Bus released, pins off and interrupt quiet after a reset edge
  a_rst_idle: assert property (reset |=> sda_oe_n && int_n && pin_oe_n == 16'hFFFF)
    else $error("Outputs not idle after reset");
  a_rst_fing_off: assert property (reset |=> ((pull_up_fing | pull_dn_fing) == 64'h0)
    && pin_o == 16'h0000)
    else $error("Fingers or pin data not cleared by reset");
  // Stage enable follows the direction setting one cycle later
  a_oe_tracks_dir: assert property (disable iff (reset)
    !$past(reset) |-> pin_oe_n == $past(dir_in))
    else $error("Pin enable does not follow direction");
  // Pin data follows the output setting one cycle later
  a_out_tracks_val: assert property (disable iff (reset)
    !$past(reset) |-> pin_o == $past(out_val))
    else $error("Pin data does not follow output value");
  // Input pin 0 drives no finger at all
  a_input_no_drive: assert property (disable iff (reset)
    !$past(reset) && $past(dir_in[0]) |-> (pull_up_fing[3:0] | pull_dn_fing[3:0]) == 4'h0)
    else $error("Input pin has active fingers");
  // Code 00 on pin 0 driving high enables one pair
  a_one_pair_c00: assert property (disable iff (reset)
    !$past(reset) && !$past(dir_in[0]) && $past(out_val[0]) && $past(drv_code[1:0]) == 2'b00
    |-> pull_up_fing[3:0] == 4'h1)
    else $error("Code 00 does not give one pair");
  // Code 10 on pin 2 driving high enables two pairs
  a_half_c10: assert property (disable iff (reset)
    !$past(reset) && !$past(dir_in[2]) && $past(out_val[2]) && $past(drv_code[5:4]) == 2'b10
    |-> pull_up_fing[11:8] == 4'h3)
    else $error("Code 10 does not give two pairs");
  // Code 11 on pin 3 driving low enables all pairs
  a_full_c11: assert property (disable iff (reset)
    !$past(reset) && !$past(dir_in[3]) && !$past(out_val[3]) && $past(drv_code[7:6]) == 2'b11
    |-> pull_dn_fing[15:12] == 4'hF)
    else $error("Code 11 does not give four pairs");
  // High and low side never on together
  a_sides_apart: assert property (disable iff (reset)
    (pull_up_fing & pull_dn_fing) == 64'h0)
    else $error("Both sides of a pin enabled");
  // Main scenarios reached
  c_ack: cover property ($fell(sda_oe_n));
  c_half: cover property (pull_up_fing[11:8] == 4'h3);
  c_int: cover property ($fell(int_n));
endmodule
bind gxrp_core gxrp_chk chk (
  .ref_clk, .reset, .scl_i, .sda_i, .sda_o, .sda_oe_n, .addr_sel, .pin_i, .out_val,
  .dir_in, .drv_code, .pin_o, .pin_oe_n, .pull_up_fing, .pull_dn_fing, .int_n
);

/* gxrp_core.sv */
// Serial read path of a 16-bit I/O expander acting as a bus target,
// with per-pin drive strength finger control.
// Assumes SCL, SDA and port pins are asynchronous to ref_clk, and that
// the output, direction and drive settings come from ref_clk logic.
`timescale 1ns/10ps

module gxrp_core (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic [2:0] addr_sel,
  input wire logic [15:0] pin_i,
  input wire logic [15:0] out_val,
  input wire logic [15:0] dir_in,
  input wire logic [31:0] drv_code,
  output logic [15:0] pin_o,
  output logic [15:0] pin_oe_n,
  output logic [63:0] pull_up_fing,
  output logic [63:0] pull_dn_fing,
  output logic int_n
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [17:0] raw;   // Pins, SCL and SDA as they arrive
  logic [17:0] s1_q;  // First stage, read only by the second
  logic [17:0] s2_q, s3_q;  // Second and third stage
  logic [17:0] f_d, f_q;  // Agreed level, next and current
  logic [17:0] fp_q;  // Agreed level one cycle back

  assign raw = {sda_i, scl_i, pin_i};
  // A change is accepted once the second and third stage agree
  genvar gi;
  generate
    for (gi = 0; gi < 18; gi++) begin : g_sync
      assign f_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : f_q[gi];
    end
  endgenerate
  // Synchroniser registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s1_q <= gxrp_pkg::SYNC_RST;
      s2_q <= gxrp_pkg::SYNC_RST;
      s3_q <= gxrp_pkg::SYNC_RST;
      f_q <= gxrp_pkg::SYNC_RST;
      fp_q <= gxrp_pkg::SYNC_RST;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q <= f_d;
      fp_q <= f_q;
    end
  end

  // ****************************************************************
  // Bus events
  // ****************************************************************
  logic [15:0] pins;   // Filtered port pins
  logic scl_rise;      // SCL went high
  logic scl_fall;      // SCL went low
  logic bus_start;     // SDA fell while SCL high
  logic bus_stop;      // SDA rose while SCL high

  assign pins = f_q[15:0];
  assign scl_rise = f_q[16] & ~fp_q[16];
  assign scl_fall = ~f_q[16] & fp_q[16];
  assign bus_start = f_q[16] & fp_q[16] & ~f_q[17] & fp_q[17];
  assign bus_stop = f_q[16] & fp_q[16] & f_q[17] & ~fp_q[17];

  // ****************************************************************
  // Register read selection
  // ****************************************************************
  // Byte returned for a pointer value, with input ports taken live
  function automatic logic [7:0] rd_byte(input logic [7:0] ptr, input logic [15:0] inp);
    logic [7:0] r;
    unique case (ptr)
      gxrp_pkg::CMD_IN0: r = inp[7:0];
      gxrp_pkg::CMD_IN1: r = inp[15:8];
      gxrp_pkg::CMD_OUT0: r = out_val[7:0];
      gxrp_pkg::CMD_OUT1: r = out_val[15:8];
      gxrp_pkg::CMD_DIR0: r = dir_in[7:0];
      gxrp_pkg::CMD_DIR1: r = dir_in[15:8];
      gxrp_pkg::CMD_DRV0: r = drv_code[7:0];
      gxrp_pkg::CMD_DRV1: r = drv_code[15:8];
      gxrp_pkg::CMD_DRV2: r = drv_code[23:16];
      gxrp_pkg::CMD_DRV3: r = drv_code[31:24];
      default: r = gxrp_pkg::RD_UNMAPPED;
    endcase
    return r;
  endfunction

  // ****************************************************************
  // Bus state machine
  // ****************************************************************
  gxrp_pkg::gxrp_state_e st_q, st_d;  // Current and next state
  logic [3:0] bit_q, bit_d;  // Bit count within a byte
  logic [7:0] sh_q, sh_d;  // Receive shift register
  logic [7:0] tx_q, tx_d;  // Transmit shift register
  logic rw_q, rw_d;  // Direction bit of the address
  logic nack_q, nack_d;  // Controller declined the last byte
  logic low_q, low_d;  // Pull SDA low
  logic [7:0] ptr_q, ptr_d;  // Register pointer
  logic [15:0] in_q, in_d;  // Input port register
  logic [15:0] ref_q, ref_d;  // Port state last seen by the controller
  logic [7:0] nxt;  // Byte to be loaded at an acknowledge fall

  // Next-state logic for the bus engine
  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    tx_d = tx_q;
    rw_d = rw_q;
    nack_d = nack_q;
    low_d = low_q;
    ptr_d = ptr_q;
    in_d = in_q;
    ref_d = ref_q;
    nxt = rd_byte(ptr_q, pins);
    if (bus_start) begin
      // Start or repeated start; pointer is kept across it
      st_d = gxrp_pkg::ST_ADDR;
      bit_d = 4'h0;
      low_d = 1'b0;
    end else if (bus_stop) begin
      // Stop ends everything; registers keep last acknowledged data
      st_d = gxrp_pkg::ST_IDLE;
      low_d = 1'b0;
    end else begin
      unique case (st_q)
        gxrp_pkg::ST_IDLE: low_d = 1'b0;
        gxrp_pkg::ST_ADDR: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], f_q[17]};
            bit_d = bit_q + 4'h1;
          end else if (scl_fall && bit_q == gxrp_pkg::BYTE_BITS) begin
            bit_d = 4'h0;
            if (sh_q[7:1] == {gxrp_pkg::ADDR_HI, addr_sel}) begin
              // Our address: latch direction and acknowledge
              st_d = gxrp_pkg::ST_AACK;
              rw_d = sh_q[0];
              low_d = 1'b1;
            end else begin
              st_d = gxrp_pkg::ST_SKIP;
            end
          end
        end
        gxrp_pkg::ST_AACK: begin
          if (scl_fall) begin
            bit_d = 4'h0;
            if (rw_q) begin
              // Read: capture pins and send the selected register
              in_d = pins;
              tx_d = nxt;
              low_d = ~nxt[7];
              st_d = gxrp_pkg::ST_TX;
            end else begin
              low_d = 1'b0;
              st_d = gxrp_pkg::ST_CMD;
            end
          end
        end
        gxrp_pkg::ST_CMD: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], f_q[17]};
            bit_d = bit_q + 4'h1;
          end else if (scl_fall && bit_q == gxrp_pkg::BYTE_BITS) begin
            // Command byte selects the register
            ptr_d = sh_q;
            bit_d = 4'h0;
            low_d = 1'b1;
            st_d = gxrp_pkg::ST_CACK;
          end
        end
        gxrp_pkg::ST_CACK: begin
          if (scl_fall) begin
            // Write data is not handled; wait for restart or stop
            low_d = 1'b0;
            st_d = gxrp_pkg::ST_SKIP;
          end
        end
        gxrp_pkg::ST_TX: begin
          if (scl_fall) begin
            bit_d = bit_q + 4'h1;
            if (bit_q == gxrp_pkg::LAST_BIT) begin
              // Release SDA for the controller acknowledge
              low_d = 1'b0;
              st_d = gxrp_pkg::ST_MACK;
            end else begin
              tx_d = {tx_q[6:0], 1'b0};
              low_d = ~tx_q[6];
            end
          end
        end
        gxrp_pkg::ST_MACK: begin
          if (scl_rise) begin
            nack_d = f_q[17];
            // Port just read is now seen; interrupt source clears here
            if (ptr_q == gxrp_pkg::CMD_IN0) begin
              ref_d[7:0] = in_q[7:0];
            end else if (ptr_q == gxrp_pkg::CMD_IN1) begin
              ref_d[15:8] = in_q[15:8];
            end
          end else if (scl_fall) begin
            // Capture pins, step to the pair partner
            in_d = pins;
            ptr_d = ptr_q ^ gxrp_pkg::PAIR_FLIP;
            nxt = rd_byte(ptr_q ^ gxrp_pkg::PAIR_FLIP, pins);
            bit_d = 4'h0;
            if (nack_q) begin
              // Controller is done; any length is accepted
              low_d = 1'b0;
              st_d = gxrp_pkg::ST_SKIP;
            end else begin
              tx_d = nxt;
              low_d = ~nxt[7];
              st_d = gxrp_pkg::ST_TX;
            end
          end
        end
        gxrp_pkg::ST_SKIP: low_d = 1'b0;
        default: begin
          st_d = gxrp_pkg::ST_IDLE;
          low_d = 1'b0;
        end
      endcase
    end
  end

  // Bus engine registers; reset returns all to defaults
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q <= gxrp_pkg::ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      low_q <= 1'b0;
      ptr_q <= gxrp_pkg::PTR_RST;
      in_q <= gxrp_pkg::PORT_RST;
      ref_q <= gxrp_pkg::PORT_RST;
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      rw_q <= rw_d;
      nack_q <= nack_d;
      low_q <= low_d;
      ptr_q <= ptr_d;
      in_q <= in_d;
      ref_q <= ref_d;
    end
  end

  // SDA is open drain: drive low only
  assign sda_o = 1'b0;
  assign sda_oe_n = ~low_q;

  // ****************************************************************
  // Output stage control
  // ****************************************************************
  logic [63:0] pu_d, pu_q;  // High-side finger enables
  logic [63:0] pd_d, pd_q;  // Low-side finger enables
  logic [15:0] oen_d, oen_q;  // Pin enables
  logic [15:0] po_q;  // Pin data
  logic irq_d, irq_q;  // Input differs from last read value
  // Per-pin finger selection from strength, direction and data
  genvar gp;
  generate
    for (gp = 0; gp < 16; gp++) begin : g_pin
      logic [3:0] mask;  // Active finger pairs for this pin
      always_comb begin
        mask = gxrp_pkg::FING_00;
        unique case (drv_code[2*gp +: 2])
          2'h0: mask = gxrp_pkg::FING_00;
          2'h1: mask = gxrp_pkg::FING_01;
          2'h2: mask = gxrp_pkg::FING_10;
          2'h3: mask = gxrp_pkg::FING_11;
        endcase
      end
      // Only an output pin drives, high or low side by its data
      assign pu_d[4*gp +: 4] = (~dir_in[gp] & out_val[gp]) ? mask : 4'h0;
      assign pd_d[4*gp +: 4] = (~dir_in[gp] & ~out_val[gp]) ? mask : 4'h0;
      assign oen_d[gp] = dir_in[gp];
    end
  endgenerate
  // Interrupt request: an input pin changed since the controller saw it
  assign irq_d = |((pins ^ ref_q) & dir_in);

  // Output stage registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pu_q <= 64'h0000000000000000;
      pd_q <= 64'h0000000000000000;
      oen_q <= 16'hFFFF;
      po_q <= 16'h0000;
      irq_q <= 1'b0;
    end else begin
      pu_q <= pu_d;
      pd_q <= pd_d;
      oen_q <= oen_d;
      po_q <= out_val;
      irq_q <= irq_d;
    end
  end
  assign pull_up_fing = pu_q;
  assign pull_dn_fing = pd_q;
  assign pin_oe_n = oen_q;
  assign pin_o = po_q;
  assign int_n = ~irq_q;

endmodule

/* gxrp_core_tb.sv */
// Self-checking bench for the expander read path and pin output stage.
// Assumes gxrp_core, gxrp_ctrl and the bound checker are compiled first.
`timescale 1ns/10ps
module gxrp_core_tb;
  logic ref_clk, reset, scl, sda_rel, sda_o, sda_oe_n, int_n;
  logic [2:0] addr_sel;
  logic [6:0] dev_addr;
  logic [15:0] pin_i, out_val, dir_in, pin_o, pin_oe_n;
  logic [31:0] drv_code;
  logic [63:0] pull_up_fing, pull_dn_fing;
  wire sda;
  int miscompares, comparisons;
  // Open-drain wire with pull-up: low while either party pulls
  assign sda = (sda_oe_n | sda_o) & sda_rel;
  assign dev_addr = {gxrp_pkg::ADDR_HI, addr_sel};
  gxrp_core dut (.ref_clk(ref_clk), .reset(reset), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .addr_sel(addr_sel), .pin_i(pin_i), .out_val(out_val),
    .dir_in(dir_in), .drv_code(drv_code), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
    .pull_up_fing(pull_up_fing), .pull_dn_fing(pull_dn_fing), .int_n(int_n));
  gxrp_ctrl ctrl (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_rel(sda_rel));
  // ************************************************************
  // Clock, compare, verdict and shared bus steps
  // ************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Start, then own address with direction bit
  task automatic addr_phase(input logic rd, output logic ack);
    ctrl.start();
    ctrl.put_byte({dev_addr, rd}, ack);
  endtask
  // Outputs idle after power-on reset
  task automatic s_reset_state();
    chk(sda_oe_n, 1'b1); // Bus released
    chk(pin_oe_n, 16'hFFFF); // All pins off
    chk(pull_up_fing | pull_dn_fing, 64'h0); // No finger on
    chk(int_n, 1'b1); // Interrupt quiet
    chk(pin_o, 16'h0000); // Pin data cleared
  endtask
  // Input pair read, capture point, interrupt clear and restart
  task automatic s_read_inputs();
    logic a;
    logic [7:0] b;
    pin_i = 16'hA55A;
    ctrl.tick(20);
    chk(int_n, 1'b0); // Pins differ from reference
    addr_phase(1'b0, a);
    chk(a, 1'b1); // Write address taken
    ctrl.put_byte(gxrp_pkg::CMD_IN0, a);
    chk(a, 1'b1); // Command taken
    addr_phase(1'b1, a);
    chk(a, 1'b1); // Read address taken
    ctrl.get_byte(1'b0, b);
    chk(b, 8'h5A); // Port 0 first
    ctrl.tick(8);
    pin_i = 16'h963C;
    ctrl.get_byte(1'b0, b);
    chk(b, 8'hA5); // Captured at earlier acknowledge
    ctrl.get_byte(1'b0, b);
    chk(b, 8'h3C); // Back to port 0
    ctrl.get_byte(1'b1, b);
    chk(b, 8'h96); // Last byte ends the read
    ctrl.stop();
    chk(int_n, 1'b1); // Both ports read
    addr_phase(1'b1, a);
    ctrl.get_byte(1'b1, b);
    chk(b, 8'h3C); // Partner after restart
    ctrl.stop();
  endtask
  // Finger masks per code and side, then the drive pair over the bus
  task automatic s_drive_stage();
    logic a;
    logic [7:0] b;
    dir_in = 16'hFFF0;
    out_val = 16'h0005;
    drv_code = 32'h0000_1BE4;
    ctrl.tick(2);
    chk(pin_oe_n, 16'hFFF0); // Outputs enabled
    chk(pull_up_fing, 64'h0301); // Codes 00 and 10 high
    chk(pull_dn_fing, 64'hF030); // Codes 01 and 11 low
    out_val = 16'h000A;
    ctrl.tick(2);
    chk(pin_o, 16'h000A); // Data follows
    chk(pull_up_fing, 64'hF030); // Per-pin codes high
    chk(pull_dn_fing, 64'h0301); // Per-pin codes low
    addr_phase(1'b0, a);
    ctrl.put_byte(gxrp_pkg::CMD_DRV1, a);
    addr_phase(1'b1, a);
    ctrl.get_byte(1'b0, b);
    chk(b, 8'h1B); // Selected register
    ctrl.get_byte(1'b1, b);
    chk(b, 8'hE4); // Lower partner next
    ctrl.stop();
    dir_in = 16'hFFFF;
  endtask
  // Foreign address, abort by stop, reset in mid-read
  task automatic s_abort_reset();
    logic a, s;
    logic [7:0] b;
    addr_sel = 3'h2;
    ctrl.tick(2);
    ctrl.start();
    ctrl.put_byte({gxrp_pkg::ADDR_HI, 3'h5, 1'b0}, a);
    chk(a, 1'b0); // Old strap address ignored
    ctrl.stop();
    ctrl.start();
    repeat (2) ctrl.bit_io(1'b0, s);
    ctrl.stop();
    addr_phase(1'b1, a);
    ctrl.get_byte(1'b1, b);
    chk(b, 8'h1B); // Pointer kept over the abort
    addr_phase(1'b1, a);
    repeat (4) ctrl.bit_io(1'b1, s);
    reset = 1'b1;
    ctrl.tick(2);
    chk(sda_oe_n, 1'b1); // Reset frees the bus
    reset = 1'b0;
    ctrl.stop();
    ctrl.tick(10);
    addr_phase(1'b1, a);
    ctrl.get_byte(1'b1, b);
    chk(b, 8'h3C); // Pointer back to port 0
    ctrl.stop();
  endtask
  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  initial begin
    reset = 1'b1;
    addr_sel = 3'h5;
    pin_i = 16'h0000;
    out_val = 16'h0000;
    dir_in = 16'hFFFF;
    drv_code = 32'h0000_0000;
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    ctrl.tick(10);
    s_reset_state();
    s_read_inputs();
    s_drive_stage();
    s_abort_reset();
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    end_sim();
  end
endmodule

/* gxrp_ctrl.sv */
// Bus controller model: start, stop, byte write and byte read, SCL at 320 ns.
// Assumes an open-drain SDA wire with pull-up; changes at ref_clk falls.
`timescale 1ns/10ps
module gxrp_ctrl (
  input wire logic ref_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_rel
);
  // SCL idles high and stands still between frames
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // Wait a number of ref_clk falls
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Start or repeated start: SDA falls while SCL is high
  task automatic start();
    sda_rel = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_rel = 1'b0;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask
  // Stop: SDA rises while SCL is high
  task automatic stop();
    sda_rel = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_rel = 1'b1;
    tick(4);
  endtask
  // One bit: data set in low phase, wire sampled at end of high phase
  // Low phase is six ref_clk cycles: the target answers about five
  // cycles after a fall, and must settle before SCL rises again
  task automatic bit_io(input logic b, output logic s);
    sda_rel = b;
    tick(4);
    scl = 1'b1;
    tick(2);
    s = sda;
    scl = 1'b0;
    tick(2);
  endtask
  // Address or command byte, MSB first; returns the target's acknowledge
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  // Read byte; last one answered with not-acknowledge
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(last, s);
  endtask
endmodule

/* gxrp_pkg.sv */
// Package for the expander read path: bus address, command codes,
// state encoding, drive-strength finger masks and reset values.
// Assumes the link is sampled by ref_clk at 25 MHz.
package gxrp_pkg;

  // ****************************************************************
  // Bus addressing and byte framing
  // ****************************************************************
  localparam logic [3:0] ADDR_HI = 4'h4;     // Fixed upper address nibble
  localparam logic [3:0] BYTE_BITS = 4'h8;   // Bits per byte on the bus
  localparam logic [3:0] LAST_BIT = 4'h7;    // Index of the last data bit
  localparam logic [7:0] PAIR_FLIP = 8'h01;  // Pointer bit picking the pair partner

  // ****************************************************************
  // Command codes of readable registers
  // ****************************************************************
  localparam logic [7:0] CMD_IN0 = 8'h00;   // Input port 0
  localparam logic [7:0] CMD_IN1 = 8'h01;   // Input port 1
  localparam logic [7:0] CMD_OUT0 = 8'h02;  // Output port 0
  localparam logic [7:0] CMD_OUT1 = 8'h03;  // Output port 1
  localparam logic [7:0] CMD_DIR0 = 8'h06;  // Direction port 0
  localparam logic [7:0] CMD_DIR1 = 8'h07;  // Direction port 1
  localparam logic [7:0] CMD_DRV0 = 8'h40;  // Drive codes pins 0..3
  localparam logic [7:0] CMD_DRV1 = 8'h41;  // Drive codes pins 4..7
  localparam logic [7:0] CMD_DRV2 = 8'h42;  // Drive codes pins 8..11
  localparam logic [7:0] CMD_DRV3 = 8'h43;  // Drive codes pins 12..15
  localparam logic [7:0] RD_UNMAPPED = 8'h00; // Value of unknown commands

  // ****************************************************************
  // Drive strength finger masks (one bit per finger pair)
  // ****************************************************************
  localparam logic [3:0] FING_00 = 4'h1;  // Quarter strength
  localparam logic [3:0] FING_01 = 4'h3;  // Half strength
  localparam logic [3:0] FING_10 = 4'h3;  // Half strength
  localparam logic [3:0] FING_11 = 4'hF;  // Full strength

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [17:0] SYNC_RST = 18'h30000; // Bus lines idle high, pins low
  localparam logic [7:0] PTR_RST = 8'h00;        // Pointer after reset
  localparam logic [15:0] PORT_RST = 16'h0000;   // Input and reference bytes

  // ****************************************************************
  // Bus state machine
  // ****************************************************************
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,  // Waiting for a start
    ST_ADDR = 8'h02,  // Shifting in address and direction
    ST_AACK = 8'h04,  // Acknowledging the address
    ST_CMD = 8'h08,   // Shifting in the command byte
    ST_CACK = 8'h10,  // Acknowledging the command byte
    ST_TX = 8'h20,    // Shifting out a data byte
    ST_MACK = 8'h40,  // Controller acknowledge slot
    ST_SKIP = 8'h80   // Ignoring the bus until start or stop
  } gxrp_state_e;

endpackage
